// ===== logic/gpio_regs.svh
/*
 Register offsets, reset values, field positions and read fillers for the
 port 4 to 6 pin logic. Assumes an 8-bit register port with a 4-bit address.
*/
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH

// Register offsets on the 4-bit address port
`define OFS_INPUT_GROUP_PIN_LEVELS 4'h0
`define OFS_MIXED_PORT_DIRECTION 4'h1
`define OFS_MIXED_PORT_OUTPUT_LATCH 4'h2
`define OFS_MIXED_PORT_PIN_LEVELS 4'h3
`define OFS_SIX_PIN_PORT_DIRECTION 4'h4
`define OFS_INTERRUPT_PIN_SELECT 4'h5

// Reset values
`define RST_MIXED_DIR 4'h0
`define RST_MIXED_LATCH 4'h0
`define RST_SIX_DIR 6'h00
`define RST_IRQ_SELECT 8'h00
`define RST_READ_DATA 8'h00

// Fillers for write-only and reserved read bits
`define FILL_MIXED_DIR_READ 8'hff
`define FILL_SIX_DIR_READ 6'h3f
`define FILL_RESERVED_ZERO 2'h0
`define FILL_LATCH_UPPER 4'h0
`define FILL_UNMAPPED 8'h00

// Field positions inside the mixed port and the six-pin port
`define MIX_LO_MSB 3
`define MIX_HI_LSB 4
`define MIX_HI_MSB 7
`define MIX_TRG_BIT 3
`define MIX_CLK_BIT 2
`define MIX_RXD_BIT 1
`define MIX_TXD_BIT 0
`define SIX_MSB 5

// Synchroniser fill count after reset
`define SYNC_FILL_RESET 2'h0
`define SYNC_FILL_STEP 2'h1
`define SYNC_FILL_DONE 2'h2

// Inactive level of the active-low request lines
`define REQ_IDLE 1'b1

`endif

// ===== logic/gpio_pkg.sv
/*
 Types shared by the port 4 to 6 pin logic.
 Assumes the constants come from gpio_regs.svh.
*/
package gpio_pkg;

	// Register selected by the current address
	typedef enum {
		SEL_INPUT_LEVELS,
		SEL_MIXED_DIR,
		SEL_MIXED_LATCH,
		SEL_MIXED_LEVELS,
		SEL_SIX_DIR,
		SEL_IRQ_SELECT,
		SEL_NONE
	} reg_sel_t;

	typedef logic [7:0] byte_t;
	typedef logic [3:0] nibble_t;

endpackage : gpio_pkg

// ===== logic/pin_sync.sv
/*
 Two-stage synchroniser for a group of external pin levels.
 Assumes the pins are quasi-static compared with the system clock.
*/
`timescale 1ns/10ps

module pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Pins and synchronised levels
	input wire logic [WIDTH-1:0] pins,
	output logic [WIDTH-1:0] levels
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] level_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_r <= '0;
			level_r <= '0;
		end
		else
		begin
			meta_r <= pins;
			level_r <= meta_r;
		end
	end

	assign levels = level_r;

endmodule : pin_sync

// ===== logic/mixed_pin_mux.sv
/*
 Output and enable selection for the four two-way mixed port pins.
 Assumes the serial channel control bits arrive as levels from that channel.
*/
`timescale 1ns/10ps
`include "gpio_regs.svh"

module mixed_pin_mux (
	// General I/O settings
	input wire logic [3:0] dir,
	input wire logic [3:0] latch,
	// Serial channel ownership
	input wire logic clock_enable_high,
	input wire logic clock_enable_low,
	input wire logic clocked_mode,
	input wire logic receive_enable,
	input wire logic transmit_enable,
	input wire logic ser_clk_out,
	input wire logic ser_txd,
	// Next pin drive
	output logic [3:0] out_nxt,
	output logic [3:0] oe_nxt
);

	wire clk_is_input = clock_enable_high;
	wire clk_is_output = !clock_enable_high && (clocked_mode || clock_enable_low);

	// Trigger pin keeps plain general I/O behaviour
	assign out_nxt[`MIX_TRG_BIT] = latch[`MIX_TRG_BIT];
	assign oe_nxt[`MIX_TRG_BIT] = dir[`MIX_TRG_BIT];

	// Clock pin: input wins, then output, else general I/O
	assign out_nxt[`MIX_CLK_BIT] = clk_is_output ? ser_clk_out : latch[`MIX_CLK_BIT];
	assign oe_nxt[`MIX_CLK_BIT] = clk_is_input ? 1'b0 :
		(clk_is_output ? 1'b1 : dir[`MIX_CLK_BIT]);

	// Receive pin is forced to input while receiving
	assign out_nxt[`MIX_RXD_BIT] = latch[`MIX_RXD_BIT];
	assign oe_nxt[`MIX_RXD_BIT] = receive_enable ? 1'b0 : dir[`MIX_RXD_BIT];

	// Transmit pin carries channel data while transmitting
	assign out_nxt[`MIX_TXD_BIT] = transmit_enable ? ser_txd : latch[`MIX_TXD_BIT];
	assign oe_nxt[`MIX_TXD_BIT] = transmit_enable ? 1'b1 : dir[`MIX_TXD_BIT];

endmodule : mixed_pin_mux

// ===== logic/input_group_pin_levels_to_6_gpio.sv
/*
 General-purpose pin logic for three port groups: an eight-pin input-only
 group, a mixed port with four two-way and four input-only pins, and the
 direction register of a six-pin two-way port.
 Assumes an 8-bit register port with read data one cycle after the read
 strobe, and serial and converter blocks elsewhere that supply
 their control levels as ports.
 Request outputs stay idle for the first two edges after reset while the
 pin synchronisers fill, so a reset never shows up as a pin edge on an
 interrupt, trigger or serial input.
*/
// The implementer's own choices: the register addresses and the plain strobed port.
// Notes on behaviour
// - Input group level register, read only
// - Input group reads live levels, no direction
// - Mixed port: two-way low half, input upper
// - Mixed direction reads undefined, never stored bits
// - Direction one drives, zero inputs, reset zero
// - Mixed direction upper bits reserved, read undefined
// - Output latch low four bits, reset zero
// - Output latch upper bits read zero, ignored
// - Mixed level register upper bits live, read only
// - Low bits read latch if output, else pin
// - Interrupt request follows pin while select zero
// - Pin three triggers converter when sources zero
// - Pin two serial clock in, out, else I/O
// - Pin one receives while receive enabled
// - Pin zero transmits while transmit enabled
// - Six-pin port is two-way, shared with peripherals
// - Six-pin direction write only, reads undefined
// - Six-pin direction one output, reset zero
// - Six-pin direction reserved bits read zero
`timescale 1ns/10ps
`include "gpio_regs.svh"

module input_group_pin_levels_to_6_gpio (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// Register port
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic WR_STROBE,
	input wire logic RD_STROBE,
	output logic [7:0] RD_DATA,
	// Input-only group pins
	input wire logic [7:0] INPUT_GROUP_PIN,
	// Mixed port pins
	input wire logic [7:0] MIXED_PIN_IN,
	output logic [3:0] MIXED_PIN_OUT,
	output logic [3:0] MIXED_PIN_OE,
	// Six-pin port pins
	input wire logic [5:0] SIX_PIN_OUT_VALUE,
	output logic [5:0] SIX_PIN_OUT,
	output logic [5:0] SIX_PIN_OE,
	// Serial channel control and data
	input wire logic CLOCK_ENABLE_HIGH,
	input wire logic CLOCK_ENABLE_LOW,
	input wire logic CLOCKED_MODE,
	input wire logic RECEIVE_ENABLE,
	input wire logic TRANSMIT_ENABLE,
	input wire logic SERIAL_CLOCK_OUT,
	input wire logic SERIAL_TRANSMIT_DATA,
	output logic SERIAL_CLOCK_IN,
	output logic SERIAL_RECEIVE_DATA,
	// Converter trigger
	input wire logic TRIGGER_SOURCE_SELECT_HIGH,
	input wire logic TRIGGER_SOURCE_SELECT_LOW,
	output logic CONVERTER_EXTERNAL_TRIGGER_N,
	// Interrupt requests
	output logic [7:0] IRQ_REQUEST_N
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	// Decode results and next pin drive
	gpio_pkg::reg_sel_t sel;
	gpio_pkg::byte_t input_levels;
	gpio_pkg::byte_t mixed_levels;
	gpio_pkg::byte_t read_mux;
	gpio_pkg::byte_t read_data_nxt;
	gpio_pkg::nibble_t mixed_out_nxt;
	gpio_pkg::nibble_t mixed_oe_nxt;

	// Synchroniser fill and request values
	logic [1:0] fill_nxt;
	logic sync_full;
	logic clock_in_nxt;
	logic rxd_nxt;
	logic trigger_nxt;
	gpio_pkg::nibble_t irq_hi_nxt;
	gpio_pkg::nibble_t irq_lo_nxt;
	gpio_pkg::byte_t irq_nxt;

	// Registers
	gpio_pkg::nibble_t mixed_dir_r;
	gpio_pkg::nibble_t mixed_latch_r;
	logic [5:0] six_dir_r;
	gpio_pkg::byte_t irq_select_r;
	gpio_pkg::byte_t read_data_r;
	gpio_pkg::nibble_t mixed_out_r;
	gpio_pkg::nibble_t mixed_oe_r;
	logic [5:0] six_out_r;
	logic serial_clock_in_r;
	logic serial_rxd_r;
	logic trigger_n_r;
	gpio_pkg::byte_t irq_n_r;
	logic [1:0] fill_r;

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Per-bit choice between the output latch and the pin level
	function automatic gpio_pkg::nibble_t latch_or_pin(
		input gpio_pkg::nibble_t dir,
		input gpio_pkg::nibble_t latch,
		input gpio_pkg::nibble_t pin
	);
		latch_or_pin = (dir & latch) | (~dir & pin);
	endfunction : latch_or_pin

	// Request line: pin level when routed, idle level otherwise
	function automatic logic req_level(
		input logic routed,
		input logic pin
	);
		req_level = routed ? pin : `REQ_IDLE;
	endfunction : req_level

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// All pins are asynchronous to the system clock
	pin_sync #(
		.WIDTH(8)
	) u_input_group_sync (
		.clk(SYS_CLK),
		.resetn(RESETN),
		.pins(INPUT_GROUP_PIN),
		.levels(input_levels)
	);

	pin_sync #(
		.WIDTH(8)
	) u_mixed_sync (
		.clk(SYS_CLK),
		.resetn(RESETN),
		.pins(MIXED_PIN_IN),
		.levels(mixed_levels)
	);

	////////////////////////////////////////////////////////////////////////
	// Address decode

	// One register per address, everything else unmapped
	assign sel = (ADDR == `OFS_INPUT_GROUP_PIN_LEVELS) ? gpio_pkg::SEL_INPUT_LEVELS :
		(ADDR == `OFS_MIXED_PORT_DIRECTION) ? gpio_pkg::SEL_MIXED_DIR :
		(ADDR == `OFS_MIXED_PORT_OUTPUT_LATCH) ? gpio_pkg::SEL_MIXED_LATCH :
		(ADDR == `OFS_MIXED_PORT_PIN_LEVELS) ? gpio_pkg::SEL_MIXED_LEVELS :
		(ADDR == `OFS_SIX_PIN_PORT_DIRECTION) ? gpio_pkg::SEL_SIX_DIR :
		(ADDR == `OFS_INTERRUPT_PIN_SELECT) ? gpio_pkg::SEL_IRQ_SELECT :
		gpio_pkg::SEL_NONE;

	wire wr_mixed_dir = WR_STROBE && (sel == gpio_pkg::SEL_MIXED_DIR);
	wire wr_mixed_latch = WR_STROBE && (sel == gpio_pkg::SEL_MIXED_LATCH);
	wire wr_six_dir = WR_STROBE && (sel == gpio_pkg::SEL_SIX_DIR);
	wire wr_irq_select = WR_STROBE && (sel == gpio_pkg::SEL_IRQ_SELECT);

	////////////////////////////////////////////////////////////////////////
	// Writable registers

	// Mixed direction: only the two-way half is stored
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			mixed_dir_r <= `RST_MIXED_DIR;
		else if (wr_mixed_dir)
			mixed_dir_r <= WR_DATA[`MIX_LO_MSB:0];
	end

	// Output latch: upper write bits are dropped
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			mixed_latch_r <= `RST_MIXED_LATCH;
		else if (wr_mixed_latch)
			mixed_latch_r <= WR_DATA[`MIX_LO_MSB:0];
	end

	// Six-pin direction, reserved bits never stored
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			six_dir_r <= `RST_SIX_DIR;
		else if (wr_six_dir)
			six_dir_r <= WR_DATA[`SIX_MSB:0];
	end

	// Interrupt pin selection
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			irq_select_r <= `RST_IRQ_SELECT;
		else if (wr_irq_select)
			irq_select_r <= WR_DATA;
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Level registers ignore writes by having no write decode
	assign read_mux =
		(sel == gpio_pkg::SEL_INPUT_LEVELS) ? input_levels :
		(sel == gpio_pkg::SEL_MIXED_DIR) ? `FILL_MIXED_DIR_READ :
		(sel == gpio_pkg::SEL_MIXED_LATCH) ? {`FILL_LATCH_UPPER, mixed_latch_r} :
		(sel == gpio_pkg::SEL_MIXED_LEVELS) ?
			{mixed_levels[`MIX_HI_MSB:`MIX_HI_LSB],
			latch_or_pin(mixed_dir_r, mixed_latch_r, mixed_levels[`MIX_LO_MSB:0])} :
		(sel == gpio_pkg::SEL_SIX_DIR) ? {`FILL_RESERVED_ZERO, `FILL_SIX_DIR_READ} :
		(sel == gpio_pkg::SEL_IRQ_SELECT) ? irq_select_r :
		`FILL_UNMAPPED;

	// Data stands only in the cycle after the strobe
	assign read_data_nxt = RD_STROBE ? read_mux : `RST_READ_DATA;

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			read_data_r <= `RST_READ_DATA;
		else
			read_data_r <= read_data_nxt;
	end

	assign RD_DATA = read_data_r;

	////////////////////////////////////////////////////////////////////////
	// Mixed port pin drive

	// Only the low half has drivers; the upper half is input only
	mixed_pin_mux u_mixed_pin_mux (
		.dir(mixed_dir_r),
		.latch(mixed_latch_r),
		.clock_enable_high(CLOCK_ENABLE_HIGH),
		.clock_enable_low(CLOCK_ENABLE_LOW),
		.clocked_mode(CLOCKED_MODE),
		.receive_enable(RECEIVE_ENABLE),
		.transmit_enable(TRANSMIT_ENABLE),
		.ser_clk_out(SERIAL_CLOCK_OUT),
		.ser_txd(SERIAL_TRANSMIT_DATA),
		.out_nxt(mixed_out_nxt),
		.oe_nxt(mixed_oe_nxt)
	);

	// Registered drive; costs one cycle of latency on the serial clock
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			mixed_out_r <= `RST_MIXED_LATCH;
			mixed_oe_r <= `RST_MIXED_DIR;
		end
		else
		begin
			mixed_out_r <= mixed_out_nxt;
			mixed_oe_r <= mixed_oe_nxt;
		end
	end

	assign MIXED_PIN_OUT = mixed_out_r;
	assign MIXED_PIN_OE = mixed_oe_r;

	////////////////////////////////////////////////////////////////////////
	// Six-pin port drive

	// Output value belongs to the port's data logic elsewhere
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			six_out_r <= `RST_SIX_DIR;
		else
			six_out_r <= SIX_PIN_OUT_VALUE;
	end

	assign SIX_PIN_OUT = six_out_r;
	assign SIX_PIN_OE = six_dir_r;

	////////////////////////////////////////////////////////////////////////
	// Peripheral inputs taken from the mixed port

	// Synchroniser stages reset low, but request pins idle high
	assign fill_nxt = sync_full ? fill_r : fill_r + `SYNC_FILL_STEP;
	// Full once both stages have taken a real pin sample
	assign sync_full = (fill_r == `SYNC_FILL_DONE);

	// Saturates, so it costs nothing once the port is running
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			fill_r <= `SYNC_FILL_RESET;
		else
			fill_r <= fill_nxt;
	end

	// Routing decisions, all held off until the synchroniser is full
	wire clk_routed = sync_full && CLOCK_ENABLE_HIGH;
	wire rxd_routed = sync_full && RECEIVE_ENABLE;
	wire trg_routed = sync_full && !TRIGGER_SOURCE_SELECT_HIGH && !TRIGGER_SOURCE_SELECT_LOW;

	// Single-bit request values: pin level when routed, idle otherwise
	assign clock_in_nxt = req_level(clk_routed, mixed_levels[`MIX_CLK_BIT]);
	assign rxd_nxt = req_level(rxd_routed, mixed_levels[`MIX_RXD_BIT]);
	assign trigger_nxt = req_level(trg_routed, mixed_levels[`MIX_TRG_BIT]);

	// Requests 7 to 4 from the input-only half, 3 to 0 from the two-way half
	assign irq_hi_nxt = mixed_levels[`MIX_HI_MSB:`MIX_HI_LSB]
		| irq_select_r[`MIX_HI_MSB:`MIX_HI_LSB];
	assign irq_lo_nxt = mixed_levels[`MIX_LO_MSB:0] | irq_select_r[`MIX_LO_MSB:0];
	assign irq_nxt = sync_full ? {irq_hi_nxt, irq_lo_nxt} : {8{`REQ_IDLE}};

	// Requests idle high when not routed so no spurious edge
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			serial_clock_in_r <= `REQ_IDLE;
			serial_rxd_r <= `REQ_IDLE;
			trigger_n_r <= `REQ_IDLE;
			irq_n_r <= {8{`REQ_IDLE}};
		end
		else
		begin
			serial_clock_in_r <= clock_in_nxt;
			serial_rxd_r <= rxd_nxt;
			trigger_n_r <= trigger_nxt;
			irq_n_r <= irq_nxt;
		end
	end

	assign SERIAL_CLOCK_IN = serial_clock_in_r;
	assign SERIAL_RECEIVE_DATA = serial_rxd_r;
	assign CONVERTER_EXTERNAL_TRIGGER_N = trigger_n_r;
	assign IRQ_REQUEST_N = irq_n_r;

endmodule : input_group_pin_levels_to_6_gpio

// ===== verif/input_group_pin_levels_to_6_gpio_assertions.sv
/*
 Checker for the port 4 to 6 pin logic, bound to its top module.
 Assumes read data one cycle after the read strobe.
*/
`timescale 1ns/10ps
module input_group_pin_levels_to_6_gpio_checker (
	// Clock, reset and register port
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic [3:0] ADDR,
	input wire logic RD_STROBE,
	input wire logic [7:0] RD_DATA,
	// Mixed port pins
	input wire logic [7:0] MIXED_PIN_IN,
	input wire logic [3:0] MIXED_PIN_OUT,
	input wire logic [3:0] MIXED_PIN_OE,
	// Peripheral controls and requests
	input wire logic TRANSMIT_ENABLE,
	input wire logic SERIAL_TRANSMIT_DATA,
	input wire logic RECEIVE_ENABLE,
	input wire logic CLOCK_ENABLE_HIGH,
	input wire logic TRIGGER_SOURCE_SELECT_HIGH,
	input wire logic TRIGGER_SOURCE_SELECT_LOW,
	input wire logic CONVERTER_EXTERNAL_TRIGGER_N,
	input wire logic [7:0] IRQ_REQUEST_N
);
	// One clock domain, nothing judged in reset
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	////////////////////////////////////////
	property p_dir_read;
		RD_STROBE && ADDR == 4'h1 |=> RD_DATA == 8'hff;
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("direction read");
	property p_six_read;
		RD_STROBE && ADDR == 4'h4 |=> RD_DATA[7:6] == 2'h0;
	endproperty
	a_six_read: assert property (p_six_read) else $error("six-pin reserved");
	property p_latch_hi;
		RD_STROBE && ADDR == 4'h2 |=> RD_DATA[7:4] == 4'h0;
	endproperty
	a_latch_hi: assert property (p_latch_hi) else $error("latch upper");
	property p_tx;
		TRANSMIT_ENABLE |=> MIXED_PIN_OE[0] && MIXED_PIN_OUT[0] == $past(SERIAL_TRANSMIT_DATA);
	endproperty
	a_tx: assert property (p_tx) else $error("transmit pin");
	property p_rx;
		RECEIVE_ENABLE |=> !MIXED_PIN_OE[1];
	endproperty
	a_rx: assert property (p_rx) else $error("receive pin");
	property p_sck_in;
		CLOCK_ENABLE_HIGH |=> !MIXED_PIN_OE[2];
	endproperty
	a_sck_in: assert property (p_sck_in) else $error("clock input pin");
	property p_trig;
		TRIGGER_SOURCE_SELECT_HIGH || TRIGGER_SOURCE_SELECT_LOW |=> CONVERTER_EXTERNAL_TRIGGER_N;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger idle");
	property p_irq;
		MIXED_PIN_IN[6] [*4] |=> IRQ_REQUEST_N[6];
	endproperty
	a_irq: assert property (p_irq) else $error("request follows pin");
	property p_sync;
		(!MIXED_PIN_IN[5]) [*3] ##1 (MIXED_PIN_IN[5] && !IRQ_REQUEST_N[5]) |=> !IRQ_REQUEST_N[5];
	endproperty
	a_sync: assert property (p_sync) else $error("pin seen too early");
	property p_req_reset;
		$rose(RESETN) |=> (IRQ_REQUEST_N == 8'hff) ##1 (IRQ_REQUEST_N == 8'hff);
	endproperty
	a_req_reset: assert property (p_req_reset) else $error("request after reset");
endmodule : input_group_pin_levels_to_6_gpio_checker

// Attach to every instance of the top module
bind input_group_pin_levels_to_6_gpio input_group_pin_levels_to_6_gpio_checker checker_inst (.SYS_CLK, .RESETN, .ADDR, .RD_STROBE,
	.RD_DATA, .MIXED_PIN_IN, .MIXED_PIN_OUT, .MIXED_PIN_OE, .TRANSMIT_ENABLE, .SERIAL_TRANSMIT_DATA,
	.RECEIVE_ENABLE, .CLOCK_ENABLE_HIGH, .TRIGGER_SOURCE_SELECT_HIGH, .TRIGGER_SOURCE_SELECT_LOW,
	.CONVERTER_EXTERNAL_TRIGGER_N, .IRQ_REQUEST_N);

// ===== verif/pin_board.sv
/*
 Board model for the mixed port pins.
 Assumes the board drives only the pins that the device leaves released.
*/
`timescale 1ns/10ps
module pin_board (
	// Device drive
	input wire logic [3:0] out,
	input wire logic [3:0] oe,
	// Board levels and resolved pins
	input wire logic [7:0] ext,
	output logic [7:0] pin
);
	// Upper pins input only; low pins follow whoever drives
	assign pin = {ext[7:4], (oe & out) | (~oe & ext[3:0])};
endmodule : pin_board

// ===== verif/tb.sv
/*
 Self-checking bench for the port 4 to 6 pin logic.
 Assumes the board model resolves the mixed pins.
*/
`timescale 1ns/10ps
module tb;
	logic SYS_CLK, RESETN, WR_STROBE, RD_STROBE;
	logic [3:0] ADDR, MIXED_PIN_OUT, MIXED_PIN_OE;
	logic [7:0] WR_DATA, RD_DATA, INPUT_GROUP_PIN, MIXED_PIN_IN, IRQ_REQUEST_N, ext;
	logic [5:0] SIX_PIN_OUT_VALUE, SIX_PIN_OUT, SIX_PIN_OE;
	logic CLOCK_ENABLE_HIGH, CLOCK_ENABLE_LOW, CLOCKED_MODE, RECEIVE_ENABLE, TRANSMIT_ENABLE;
	logic SERIAL_CLOCK_OUT, SERIAL_TRANSMIT_DATA, SERIAL_CLOCK_IN, SERIAL_RECEIVE_DATA;
	logic TRIGGER_SOURCE_SELECT_HIGH, TRIGGER_SOURCE_SELECT_LOW, CONVERTER_EXTERNAL_TRIGGER_N;
	int n_errors = 0;
	int check_count = 0;
	// Device and board
	input_group_pin_levels_to_6_gpio input_group_pin_levels_to_6_gpio_inst (.SYS_CLK, .RESETN, .ADDR, .WR_DATA, .WR_STROBE, .RD_STROBE,
		.RD_DATA, .INPUT_GROUP_PIN, .MIXED_PIN_IN, .MIXED_PIN_OUT, .MIXED_PIN_OE, .SIX_PIN_OUT_VALUE,
		.SIX_PIN_OUT, .SIX_PIN_OE, .CLOCK_ENABLE_HIGH, .CLOCK_ENABLE_LOW, .CLOCKED_MODE, .RECEIVE_ENABLE,
		.TRANSMIT_ENABLE, .SERIAL_CLOCK_OUT, .SERIAL_TRANSMIT_DATA, .SERIAL_CLOCK_IN, .SERIAL_RECEIVE_DATA,
		.TRIGGER_SOURCE_SELECT_HIGH, .TRIGGER_SOURCE_SELECT_LOW, .CONVERTER_EXTERNAL_TRIGGER_N, .IRQ_REQUEST_N);
	pin_board pin_board_inst (.out(MIXED_PIN_OUT), .oe(MIXED_PIN_OE), .ext(ext), .pin(MIXED_PIN_IN));
	////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	// Settle a few edges past the launch
	task automatic wt(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask : wt
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		WR_STROBE <= 1'b1;
		ADDR <= a;
		WR_DATA <= d;
		@(posedge SYS_CLK);
		WR_STROBE <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
		@(posedge SYS_CLK);
		RD_STROBE <= 1'b1;
		ADDR <= a;
		@(posedge SYS_CLK);
		RD_STROBE <= 1'b0;
		#1;
		chk(RD_DATA, e, what);
	endtask : rd
	////////////////////////////////////////
	task automatic t_reset();
		chk({4'h0, MIXED_PIN_OE}, 8'h00, "mixed enable");
		chk({2'h0, SIX_PIN_OE}, 8'h00, "six enable");
		rd(4'h1, 8'hff, "mixed direction");
		rd(4'h2, 8'h00, "latch");
		rd(4'h4, 8'h3f, "six direction");
		$display("t_reset done");
	endtask : t_reset
	// Live levels regardless of direction, writes ignored
	task automatic t_input();
		@(posedge SYS_CLK);
		INPUT_GROUP_PIN <= 8'ha5;
		wr(4'h1, 8'h0f);
		wr(4'h0, 8'h00);
		wt(3);
		rd(4'h0, 8'ha5, "input group");
		@(posedge SYS_CLK);
		INPUT_GROUP_PIN <= 8'h5a;
		wt(3);
		rd(4'h0, 8'h5a, "input group");
		$display("t_input done");
	endtask : t_input
	task automatic t_latch();
		wr(4'h2, 8'hff);
		rd(4'h2, 8'h0f, "latch");
		$display("t_latch done");
	endtask : t_latch
	// Direction 0101, latch 1111: low bits mix latch and pins
	task automatic t_mixed();
		@(posedge SYS_CLK);
		ext <= 8'h3c;
		wr(4'h1, 8'h05);
		wt(4);
		chk({4'h0, MIXED_PIN_OE}, 8'h05, "mixed enable");
		chk({4'h0, MIXED_PIN_OUT & MIXED_PIN_OE}, 8'h05, "mixed out");
		rd(4'h3, 8'h3d, "mixed levels");
		rd(4'h1, 8'hff, "mixed direction");
		@(posedge SYS_CLK);
		ext <= 8'hc3;
		wt(4);
		rd(4'h3, 8'hc7, "mixed levels");
		$display("t_mixed done");
	endtask : t_mixed
	task automatic t_six();
		@(posedge SYS_CLK);
		SIX_PIN_OUT_VALUE <= 6'h2a;
		wr(4'h4, 8'hff);
		wt(2);
		chk({2'h0, SIX_PIN_OE}, 8'h3f, "six enable");
		chk({2'h0, SIX_PIN_OUT}, 8'h2a, "six out");
		rd(4'h4, 8'h3f, "six direction");
		$display("t_six done");
	endtask : t_six
	// Requests follow pins until the select bit is set
	task automatic t_irq();
		wr(4'h1, 8'h00);
		ext <= 8'h5a;
		wt(5);
		chk(IRQ_REQUEST_N, 8'h5a, "requests");
		@(posedge SYS_CLK);
		ext <= 8'h7a;
		wt(5);
		chk(IRQ_REQUEST_N, 8'h7a, "requests");
		wr(4'h5, 8'h0f);
		wt(3);
		chk(IRQ_REQUEST_N, 8'h7f, "requests");
		$display("t_irq done");
	endtask : t_irq
	// Serial and converter ownership over direction 1111, latch 0111
	task automatic t_periph();
		wr(4'h1, 8'h0f);
		wr(4'h2, 8'h07);
		TRANSMIT_ENABLE <= 1'b1;
		SERIAL_TRANSMIT_DATA <= 1'b0;
		RECEIVE_ENABLE <= 1'b1;
		CLOCK_ENABLE_HIGH <= 1'b1;
		ext <= 8'h46;
		wt(5);
		chk({4'h0, MIXED_PIN_OE}, 8'h09, "owned enable");
		chk({7'h0, MIXED_PIN_OUT[0]}, 8'h00, "transmit out");
		chk({6'h0, SERIAL_CLOCK_IN, SERIAL_RECEIVE_DATA}, 8'h03, "serial in");
		chk({7'h0, CONVERTER_EXTERNAL_TRIGGER_N}, 8'h00, "trigger");
		@(posedge SYS_CLK);
		ext <= 8'h40;
		SERIAL_TRANSMIT_DATA <= 1'b1;
		wt(5);
		chk({6'h0, SERIAL_CLOCK_IN, SERIAL_RECEIVE_DATA}, 8'h00, "serial in");
		chk({7'h0, MIXED_PIN_OUT[0]}, 8'h01, "transmit out");
		@(posedge SYS_CLK);
		CLOCK_ENABLE_HIGH <= 1'b0;
		CLOCKED_MODE <= 1'b1;
		SERIAL_CLOCK_OUT <= 1'b1;
		TRIGGER_SOURCE_SELECT_HIGH <= 1'b1;
		wt(3);
		chk({6'h0, MIXED_PIN_OE[2], MIXED_PIN_OUT[2]}, 8'h03, "clock out");
		chk({7'h0, CONVERTER_EXTERNAL_TRIGGER_N}, 8'h01, "trigger");
		@(posedge SYS_CLK);
		CLOCKED_MODE <= 1'b0;
		CLOCK_ENABLE_LOW <= 1'b1;
		SERIAL_CLOCK_OUT <= 1'b0;
		TRIGGER_SOURCE_SELECT_HIGH <= 1'b0;
		TRIGGER_SOURCE_SELECT_LOW <= 1'b1;
		wt(3);
		chk({6'h0, MIXED_PIN_OE[2], MIXED_PIN_OUT[2]}, 8'h02, "clock out");
		chk({7'h0, CONVERTER_EXTERNAL_TRIGGER_N}, 8'h01, "trigger");
		chk({6'h0, SERIAL_CLOCK_IN, SERIAL_RECEIVE_DATA}, 8'h02, "serial idle");
		@(posedge SYS_CLK);
		CLOCK_ENABLE_LOW <= 1'b0;
		TRANSMIT_ENABLE <= 1'b0;
		RECEIVE_ENABLE <= 1'b0;
		wt(3);
		chk({4'h0, MIXED_PIN_OE, MIXED_PIN_OUT}, 8'hf7, "released pins");
		$display("t_periph done");
	endtask : t_periph
	////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// Clock at 4 ns
	initial
	begin
		SYS_CLK = 1'b0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end
	// Hang guard
	initial
	begin
		#40000;
		n_errors++;
		end_of_test();
	end
	// Main sequence
	initial
	begin
		{RESETN, WR_STROBE, RD_STROBE, ADDR, WR_DATA, INPUT_GROUP_PIN, ext, SIX_PIN_OUT_VALUE} = '0;
		{CLOCK_ENABLE_HIGH, CLOCK_ENABLE_LOW, CLOCKED_MODE, RECEIVE_ENABLE, TRANSMIT_ENABLE} = '0;
		{SERIAL_CLOCK_OUT, SERIAL_TRANSMIT_DATA, TRIGGER_SOURCE_SELECT_HIGH, TRIGGER_SOURCE_SELECT_LOW} = '0;
		repeat (4) @(posedge SYS_CLK);
		RESETN <= 1'b1;
		wt(1);
		t_reset();
		t_input();
		t_latch();
		t_mixed();
		t_six();
		t_irq();
		t_periph();
		end_of_test();
	end
endmodule : tb
